/* core/touch_dimmer.sv */
// phase-angle touch dimmer: command decode, brightness and trigger timing
// Summary of operation
// (R01) delay set by difference of two counters
// (R02) both counters advance on one tick
// (R03) brighter level loads a lower preset
// (R04) level to preset mapping is nonlinear
// (R05) delay held between 32 and 160 ticks
// (R06) touches under 80 ms are ignored
// (R07) 80 to 320 ms touch toggles load
// (R08) touches over 320 ms are long
// (R09) long raise brightens, long lower dims
// (R10) both long while off: on, minimum
// (R11) both long while on: no change
// (R12) slave input decoded like raise/lower
// (R13) internal tick period about 50 us
// (R14) one trigger pulse per zero crossing
// (R15) trigger active low, at most one tick
// (R16) triac conduction ends pulse early
// (R17) reset leaves load off, no pulses
// (R18) brief switch-on starts at maximum
// (R19) full ramp takes about 3.8 s
// (R20) sync edges restart the delay count
// (R21) ramp steps at fixed tick intervals
`timescale 1ns/1ps
`default_nettype none
module touch_dimmer #(
    parameter int TICK_CYC   = dimmer_pkg::TICK_CYCLES,
    parameter int IGNORE_T   = dimmer_pkg::IGNORE_TICKS,
    parameter int LONG_T     = dimmer_pkg::LONG_TICKS,
    parameter int STEP_T     = dimmer_pkg::STEP_TICKS
) (
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_b_i,
    input  wire logic                           raise_input_i,
    input  wire logic                           lower_input_i,
    input  wire logic                           remote_slave_input_i,
    input  wire logic                           mains_sync_input_i,
    input  wire logic                           triac_conducting_i,
    output logic                                trig_b_o,
    output logic                                load_on_o,
    output logic [dimmer_pkg::LEVEL_W-1:0]      level_o
);
    logic [dimmer_pkg::IN_W-1:0]    sync1_q;
    logic [dimmer_pkg::IN_W-1:0]    sync2_q;
    logic                           zc_prev_q;
    logic                           zero_cross;
    logic                           triac_on;
    logic [11:0]                    tick_cnt_q;
    logic                           tick_q;
    dimmer_pkg::cmd_t               raise_cmd;
    dimmer_pkg::cmd_t               lower_cmd;
    dimmer_pkg::cmd_t               slave_cmd;
    logic                           any_brief;
    logic                           any_held;
    logic                           held_prev_q;
    logic                           slave_prev_q;
    logic                           slave_up_q;
    logic                           ramp_up;
    logic                           ramp_dn;
    logic [12:0]                    step_cnt_q;
    logic                           on_q;
    logic [dimmer_pkg::LEVEL_W-1:0] level_q;
    logic [7:0]                     delay_want;
    logic                           short_fire_q;
    logic [dimmer_pkg::CNT_W-1:0]   ref_cnt_q;
    logic [dimmer_pkg::CNT_W-1:0]   set_cnt_q;
    dimmer_pkg::phase_t             ph_q;
    dimmer_pkg::phase_t             ph_d;
    logic                           trig_b_q;

    // pins are asynchronous; only the second stage is looked at
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {triac_conducting_i, mains_sync_input_i, remote_slave_input_i,
                        lower_input_i, raise_input_i};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zc_prev_q <= 1'b0;
        end else begin
            zc_prev_q <= sync2_q[dimmer_pkg::IN_SYNC];
        end
    end

    // both edges of the sync level mark a zero crossing
    assign zero_cross = zc_prev_q ^ sync2_q[dimmer_pkg::IN_SYNC]; // [R20]
    assign triac_on   = sync2_q[dimmer_pkg::IN_TRIAC];

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (int'(tick_cnt_q) == TICK_CYC - 1) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1; // [R13]
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    touch_classifier #(.IGNORE_T(IGNORE_T), .LONG_T(LONG_T)) u_raise (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (tick_q),
        .active_i  (sync2_q[dimmer_pkg::IN_RAISE]),
        .cmd_o     (raise_cmd)
    );

    touch_classifier #(.IGNORE_T(IGNORE_T), .LONG_T(LONG_T)) u_lower (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (tick_q),
        .active_i  (sync2_q[dimmer_pkg::IN_LOWER]),
        .cmd_o     (lower_cmd)
    );

    // same timing as the plates; a single wire cannot say up or down
    touch_classifier #(.IGNORE_T(IGNORE_T), .LONG_T(LONG_T)) u_slave (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .tick_i    (tick_q),
        .active_i  (sync2_q[dimmer_pkg::IN_SLAVE]),
        .cmd_o     (slave_cmd) // [R12]
    );

    assign any_brief = raise_cmd.brief | lower_cmd.brief | slave_cmd.brief;
    assign any_held  = raise_cmd.held | lower_cmd.held | slave_cmd.held;
    // both plates together never ramp unless the slave wire is also held long
    assign ramp_up = (raise_cmd.held & ~lower_cmd.held) | (slave_cmd.held & slave_up_q); // [R09] [R11]
    assign ramp_dn = (lower_cmd.held & ~raise_cmd.held) | (slave_cmd.held & ~slave_up_q); // [R09]

    // slave long commands alternate direction each time
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            held_prev_q  <= 1'b0;
            slave_prev_q <= 1'b0;
            slave_up_q   <= 1'b0;
        end else begin
            held_prev_q  <= any_held;
            slave_prev_q <= slave_cmd.held;
            if (slave_prev_q && !slave_cmd.held) begin
                slave_up_q <= ~slave_up_q; // [R12]
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            step_cnt_q <= '0;
        end else if (!(on_q && (ramp_up || ramp_dn))) begin
            step_cnt_q <= '0;
        end else if (tick_q) begin
            step_cnt_q <= (int'(step_cnt_q) == STEP_T - 1) ? '0 : step_cnt_q + 1'b1; // [R21]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            on_q    <= 1'b0; // [R17]
            level_q <= dimmer_pkg::LVL_MIN;
        end else if (any_brief) begin
            on_q <= ~on_q; // [R07]
            if (!on_q) begin
                level_q <= dimmer_pkg::LVL_MAX; // [R18]
            end
        end else if (any_held && !held_prev_q && !on_q) begin
            on_q    <= 1'b1; // [R10]
            level_q <= dimmer_pkg::LVL_MIN;
        end else if (on_q && tick_q && int'(step_cnt_q) == STEP_T - 1) begin
            // 31 steps of STEP_T ticks span the whole range
            if (ramp_up && level_q != dimmer_pkg::LVL_MAX) begin
                level_q <= level_q + 1'b1; // [R09] [R19]
            end else if (ramp_dn && level_q != dimmer_pkg::LVL_MIN) begin
                level_q <= level_q - 1'b1; // [R09] [R19]
            end
        end
    end

    assign delay_want = dimmer_pkg::delay_of(level_q); // [R03] [R04] [R05]

    // reference counter runs the fixed 32, preset counter the remainder
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_cnt_q    <= '0;
            set_cnt_q    <= '0;
            short_fire_q <= 1'b0;
        end else if (zero_cross) begin
            ref_cnt_q    <= dimmer_pkg::REF_LOAD; // [R01] [R20]
            set_cnt_q    <= 7'(8'h80 - (delay_want - 8'(dimmer_pkg::MIN_DELAY))); // [R03]
            short_fire_q <= delay_want == 8'(dimmer_pkg::MIN_DELAY);
        end else if (tick_q) begin
            ref_cnt_q <= (ph_q == dimmer_pkg::PH_REF) ? ref_cnt_q + 1'b1 : ref_cnt_q; // [R02]
            set_cnt_q <= (ph_q == dimmer_pkg::PH_SET) ? set_cnt_q + 1'b1 : set_cnt_q; // [R02]
        end
    end

    always_comb begin
        ph_d = ph_q;
        unique case (ph_q)
            dimmer_pkg::PH_IDLE: ph_d = dimmer_pkg::PH_IDLE;
            dimmer_pkg::PH_REF: begin
                if (tick_q && ref_cnt_q == dimmer_pkg::CNT_TOP) begin
                    ph_d = short_fire_q ? dimmer_pkg::PH_FIRE : dimmer_pkg::PH_SET; // [R05]
                end
            end
            dimmer_pkg::PH_SET: begin
                if (tick_q && set_cnt_q == dimmer_pkg::CNT_TOP) begin
                    ph_d = dimmer_pkg::PH_FIRE; // [R01]
                end
            end
            dimmer_pkg::PH_FIRE: begin
                if (tick_q || triac_on) begin
                    ph_d = dimmer_pkg::PH_IDLE; // [R15] [R16]
                end
            end
        endcase
        // a new half cycle restarts timing; off means no firing at all
        if (zero_cross) begin
            ph_d = on_q ? dimmer_pkg::PH_REF : dimmer_pkg::PH_IDLE; // [R14] [R17]
        end else if (!on_q || any_brief) begin
            // switching off drops a pulse still pending in this half cycle
            ph_d = dimmer_pkg::PH_IDLE; // [R17]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ph_q     <= dimmer_pkg::PH_IDLE;
            trig_b_q <= 1'b1;
        end else begin
            ph_q     <= ph_d;
            trig_b_q <= ph_d != dimmer_pkg::PH_FIRE; // [R15]
        end
    end

    assign trig_b_o  = trig_b_q;
    assign load_on_o = on_q;
    assign level_o   = level_q;

    // helper logic for the checks below
    logic [7:0]  chk_ticks_q;
    logic [7:0]  chk_delay_q;
    logic [11:0] chk_low_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chk_ticks_q <= '0;
            chk_delay_q <= '0;
            chk_low_q   <= '0;
        end else begin
            if (zero_cross) begin
                chk_ticks_q <= '0;
                chk_delay_q <= delay_want;
            end else if (tick_q && chk_ticks_q != 8'hFF) begin
                chk_ticks_q <= chk_ticks_q + 1'b1;
            end
            chk_low_q <= trig_b_q ? '0 : chk_low_q + 1'b1;
        end
    end

    sequence s_fire;
        $fell(trig_b_q);
    endsequence

    property p_delay_exact;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_fire |-> chk_ticks_q == chk_delay_q;
    endproperty
    a_delay_exact: assert property (p_delay_exact) else $error("trigger delay differs from preset"); // [R01]

    property p_delay_range;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_fire |-> chk_ticks_q >= 8'(dimmer_pkg::MIN_DELAY) && chk_ticks_q <= 8'(dimmer_pkg::MAX_DELAY);
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("trigger delay out of range"); // [R05]

    property p_brighter_shorter;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        level_q != dimmer_pkg::LVL_MAX |-> dimmer_pkg::delay_of(level_q + 1'b1) < delay_want;
    endproperty
    a_brighter_shorter: assert property (p_brighter_shorter) else $error("preset not falling with level"); // [R03]

    property p_fire_only_on;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_fire |-> on_q && !zero_cross;
    endproperty
    a_fire_only_on: assert property (p_fire_only_on) else $error("trigger while load off"); // [R17]

    property p_pulse_width;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        int'(chk_low_q) <= TICK_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("trigger pulse too long"); // [R15]

    property p_triac_ends;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (!trig_b_q && triac_on) |=> trig_b_q;
    endproperty
    a_triac_ends: assert property (p_triac_ends) else $error("pulse kept after conduction"); // [R16]

    property p_brief_toggle;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        any_brief |=> on_q != $past(on_q);
    endproperty
    a_brief_toggle: assert property (p_brief_toggle) else $error("brief command did not toggle"); // [R07]

    property p_brief_on_max;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (any_brief && !on_q) |=> on_q && level_q == dimmer_pkg::LVL_MAX;
    endproperty
    a_brief_on_max: assert property (p_brief_on_max) else $error("brief switch-on not at maximum"); // [R18]

    property p_long_off_min;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (raise_cmd.held && lower_cmd.held && !held_prev_q && !on_q && !any_brief)
            |=> on_q && level_q == dimmer_pkg::LVL_MIN;
    endproperty
    a_long_off_min: assert property (p_long_off_min) else $error("both long did not switch on"); // [R10]

    property p_both_long_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (raise_cmd.held && lower_cmd.held && !slave_cmd.held && on_q && !any_brief)
            |=> on_q && $stable(level_q);
    endproperty
    a_both_long_hold: assert property (p_both_long_hold) else $error("both long changed state while on"); // [R11]
endmodule
`default_nettype wire

/* core/dimmer_pkg.sv */
// constants, types and the touch-input classifier of the dimmer
package dimmer_pkg;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int TICK_PERIOD_US  = 50;
    localparam int TICK_CYCLES     = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int IGNORE_MS       = 80;
    localparam int LONG_MS         = 320;
    localparam int RAMP_MS         = 3800;
    localparam int IGNORE_TICKS    = (IGNORE_MS * 1000 + TICK_PERIOD_US - 1) / TICK_PERIOD_US;
    localparam int LONG_TICKS      = (LONG_MS * 1000) / TICK_PERIOD_US;
    localparam int LEVELS          = 32;
    localparam int LEVEL_W         = 5;
    localparam int STEP_TICKS      = (RAMP_MS * 1000) / (TICK_PERIOD_US * (LEVELS - 1));
    localparam int DUR_W           = 13;
    localparam int CNT_W           = 7;
    localparam int MIN_DELAY       = 32;
    localparam int MAX_DELAY       = 160;
    localparam logic [CNT_W-1:0] REF_LOAD = 7'h60;
    localparam logic [CNT_W-1:0] CNT_TOP  = 7'h7F;
    localparam logic [LEVEL_W-1:0] LVL_MIN = 5'h00;
    localparam logic [LEVEL_W-1:0] LVL_MAX = 5'h1F;
    localparam int IN_RAISE = 0;
    localparam int IN_LOWER = 1;
    localparam int IN_SLAVE = 2;
    localparam int IN_SYNC  = 3;
    localparam int IN_TRIAC = 4;
    localparam int IN_W     = 5;

    typedef struct packed {
        logic brief;
        logic held;
    } cmd_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_REF  = 2'b01,
        PH_SET  = 2'b10,
        PH_FIRE = 2'b11
    } phase_t;

    // square law plus one tick a level: steps grow toward the dim end, no two levels share a delay
    function automatic logic [7:0] delay_of(input logic [LEVEL_W-1:0] lvl);
        int k;
        int span;
        k    = (LEVELS - 1) - int'(lvl);
        span = MAX_DELAY - MIN_DELAY - (LEVELS - 1);
        return 8'(MIN_DELAY + k + (span * k * k) / ((LEVELS - 1) * (LEVELS - 1)));
    endfunction
endpackage

`timescale 1ns/1ps
`default_nettype none
module touch_classifier #(
    parameter int IGNORE_T = dimmer_pkg::IGNORE_TICKS,
    parameter int LONG_T   = dimmer_pkg::LONG_TICKS
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              tick_i,
    input  wire logic              active_i,
    output var dimmer_pkg::cmd_t   cmd_o
);
    logic [dimmer_pkg::DUR_W-1:0] dur_q;
    logic                         active_q;
    logic                         brief_q;
    logic                         held_q;

    // saturate just past the long threshold so the count never wraps
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dur_q <= '0;
        end else if (!active_i) begin
            dur_q <= '0;
        end else if (tick_i && int'(dur_q) <= LONG_T) begin
            dur_q <= dur_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            active_q <= 1'b0;
            brief_q  <= 1'b0;
            held_q   <= 1'b0;
        end else begin
            active_q <= active_i;
            brief_q  <= active_q && !active_i && int'(dur_q) >= IGNORE_T && int'(dur_q) <= LONG_T; // [R06] [R07]
            held_q   <= active_i && int'(dur_q) > LONG_T; // [R08]
        end
    end

    assign cmd_o = '{brief: brief_q, held: held_q};

    property p_short_ignored;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (active_q && !active_i && int'(dur_q) < IGNORE_T) |=> !brief_q;
    endproperty
    a_short_ignored: assert property (p_short_ignored) else $error("short touch gave a command"); // [R06]

    property p_long_needs_time;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(held_q) |-> int'($past(dur_q)) > LONG_T && $past(active_i);
    endproperty
    a_long_needs_time: assert property (p_long_needs_time) else $error("long command too early"); // [R08]
endmodule
`default_nettype wire

/* test/mains_triac_model.sv */
// mains zero-crossing source and triac behavioural model
`timescale 1ns/1ps
`default_nettype none
module mains_triac_model #(
    parameter int HALF = 3000
) (
    input  wire logic       ref_clk_i,
    input  wire logic       trig_b_i,
    input  wire logic [7:0] fire_dly_i,
    output logic            sync_o,
    output logic            conducting_o
);
    int half_cnt = 0;
    int wait_cnt = 0;

    initial begin
        sync_o = 1'b0;
        conducting_o = 1'b0;
    end

    // sync is a polarity level, so both edges mark a crossing
    // fire_dly_i of zero: gate current too weak, triac never latches
    // once latched the triac holds until current falls to zero
    always @(posedge ref_clk_i) begin
        if (half_cnt == HALF - 1) begin
            half_cnt <= 0;
            sync_o <= ~sync_o;
            conducting_o <= 1'b0;
            wait_cnt <= 0;
        end else begin
            half_cnt <= half_cnt + 1;
            if (trig_b_i === 1'b0 && fire_dly_i != 8'h00) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt + 1 >= int'(fire_dly_i)) begin
                    conducting_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* test/touch_dimmer_tb.sv */
// self-checking bench for the touch dimmer
`timescale 1ns/1ps
`default_nettype none
module touch_dimmer_tb;
    localparam int TC   = 16;
    localparam int IGN  = 8;
    localparam int LNG  = 32;
    localparam int STP  = 2;
    localparam int HALF = 3000;

    logic                          clk = 1'b0;
    logic                          rst_b = 1'b0;
    logic                          raise = 1'b0;
    logic                          lower = 1'b0;
    logic                          slave = 1'b0;
    logic                          sync;
    logic                          cond;
    logic                          trig_b;
    logic                          load_on;
    logic [dimmer_pkg::LEVEL_W-1:0] level;
    logic [7:0]                    fire_dly = 8'h00;
    int                            err_total = 0;
    int                            checks_done = 0;
    int                            lv;

    always #12.5 clk = ~clk;

    touch_dimmer #(
        .TICK_CYC (TC),
        .IGNORE_T (IGN),
        .LONG_T   (LNG),
        .STEP_T   (STP)
    ) u_dut (
        .ref_clk_i            (clk),
        .rst_b_i              (rst_b),
        .raise_input_i        (raise),
        .lower_input_i        (lower),
        .remote_slave_input_i (slave),
        .mains_sync_input_i   (sync),
        .triac_conducting_i   (cond),
        .trig_b_o             (trig_b),
        .load_on_o            (load_on),
        .level_o              (level)
    );

    mains_triac_model #(
        .HALF (HALF)
    ) u_far (
        .ref_clk_i    (clk),
        .trig_b_i     (trig_b),
        .fire_dly_i   (fire_dly),
        .sync_o       (sync),
        .conducting_o (cond)
    );

    // square-law delay in ticks, worked out here on its own
    function automatic int d_of(input int lvl);
        int k;
        k = 31 - lvl;
        return 32 + k + (97 * k * k) / 961;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_eq(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            err_total++;
            $display("CHECK FAILED wait expected below %0d seen %0d", lim, n);
            report_and_stop();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // mask bits: slave, lower, raise
    task automatic press(input logic [2:0] m, input int ticks);
        @(posedge clk);
        #2 {slave, lower, raise} = m;
        repeat (ticks * TC) @(posedge clk);
        #2 {slave, lower, raise} = 3'b000;
        cyc(12);
    endtask

    task automatic meas_fire(input logic [7:0] dly, input int wmin, input int wmax);
        int n;
        int w;
        int d;
        logic s0;
        fire_dly = dly;
        s0 = sync;
        n = 0;
        while (sync === s0 && n < HALF + 10) begin
            cyc(1);
            n++;
        end
        guard(n, HALF + 10);
        d = d_of(int'(level));
        n = 0;
        while (trig_b !== 1'b0 && n < HALF) begin
            cyc(1);
            n++;
        end
        guard(n, HALF);
        chk_rng("fire delay", (d - 1) * TC, (d + 1) * TC + 6, n);
        w = 0;
        while (trig_b === 1'b0 && w < 2 * TC) begin
            cyc(1);
            w++;
        end
        chk_rng("pulse width", wmin, wmax, w);
    endtask

    task automatic no_fire;
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 2 * HALF; n++) begin
            cyc(1);
            if (trig_b !== 1'b1) seen = 1'b1;
        end
        chk_eq("no trigger", 8'h00, {7'h00, seen});
    endtask

    task automatic ramp_up;
        int t0;
        int t1;
        t0 = -1;
        t1 = -1;
        @(posedge clk);
        #2 raise = 1'b1;
        for (int n = 0; n < (LNG + 31 * STP + 20) * TC; n++) begin
            cyc(1);
            if (t0 < 0 && level !== 5'h00) t0 = n;
            if (t1 < 0 && level === 5'h1F) t1 = n;
        end
        #1 raise = 1'b0;
        cyc(12);
        chk_rng("ramp start", (LNG - 1) * TC, (LNG + STP + 2) * TC, t0);
        chk_rng("ramp time", 30 * STP * TC - 2, 30 * STP * TC + 2, t1 - t0);
        chk_eq("level top", 8'h1F, {3'h0, level});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #2 rst_b = 1'b1;
        cyc(2);
        chk_eq("load after reset", 8'h00, {7'h00, load_on});
        chk_eq("level after reset", 8'h00, {3'h0, level});
        no_fire();
        press(3'b001, IGN - 2);
        chk_eq("short touch", 8'h00, {7'h00, load_on});
        press(3'b001, 16);
        chk_eq("brief on", 8'h01, {7'h00, load_on});
        chk_eq("brief on level", 8'h1F, {3'h0, level});
        meas_fire(8'h00, TC / 2, TC);
        meas_fire(8'h01, 1, 5);
        press(3'b010, 16);
        chk_eq("brief off", 8'h00, {7'h00, load_on});
        no_fire();
        press(3'b011, LNG + 8);
        chk_eq("both long on", 8'h01, {7'h00, load_on});
        chk_eq("both long level", 8'h00, {3'h0, level});
        meas_fire(8'h00, TC / 2, TC);
        ramp_up();
        press(3'b010, LNG + 10);
        chk_rng("lowered level", 20, 30, int'(level));
        meas_fire(8'h02, 1, 6);
        lv = int'(level);
        press(3'b011, LNG + 8);
        chk_eq("both long while on", 8'h01, {7'h00, load_on});
        chk_eq("level kept", 8'(lv), {3'h0, level});
        press(3'b100, 16);
        chk_eq("slave brief off", 8'h00, {7'h00, load_on});
        press(3'b100, 16);
        chk_eq("slave brief on", 8'h1F, {3'h0, level});
        // first long on the slave wire ramps down
        press(3'b100, LNG + 10);
        chk_rng("slave long down", 20, 30, int'(level));
        chk_eq("slave long stays on", 8'h01, {7'h00, load_on});
        @(posedge clk);
        #2 rst_b = 1'b0;
        cyc(3);
        chk_eq("load in reset", 8'h00, {7'h00, load_on});
        chk_eq("level in reset", 8'h00, {3'h0, level});
        @(posedge clk);
        #2 rst_b = 1'b1;
        no_fire();
        report_and_stop();
    end
endmodule
`default_nettype wire
